// file: design/async_serial_receiver.sv
`timescale 1ns/100ps
`include "rx_cfg.svh"
module async_serial_receiver #(
	parameter int ADDR_W = 8
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [ADDR_W-1:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	input wire logic serial_input_pin,
	input wire logic sample_tick,
	output logic rx_char_flag,
	output logic irq_req
);
	rx_pkg::rx_top_state_type s_q, s_d;
	rx_pkg::rx_entry_type fifo_head;
	rx_pkg::rx_entry_type push_entry;
	logic [1:0] fifo_cnt;
	logic line_s;
	logic maj;
	logic fifo_push;
	logic fifo_pop;
	logic fifo_flush;
	logic rx_run;
	logic line_fall;
	logic decide;
	logic accept;
	logic bus_req;
	logic [7:0] ctrl_byte;
	logic [7:0] irqen_byte;
	logic [7:0] flag_byte;

	rx_sampler u_sampler (
		.clk(clk),
		.rst_n(rst_n),
		.serial_input_pin(serial_input_pin),
		.sample_tick(sample_tick),
		.line_s(line_s),
		.maj(maj)
	);

	rx_fifo u_fifo (
		.clk(clk),
		.rst_n(rst_n),
		.flush(fifo_flush),
		.push(fifo_push),
		.push_entry(push_entry),
		.pop(fifo_pop),
		.head(fifo_head),
		.count(fifo_cnt)
	);

	// readable bytes; framing and ninth bit come from the oldest entry
	always_comb begin
		ctrl_byte = 8'h00;
		ctrl_byte[`RX_CTRL_PORT_EN] = s_q.port_en;
		ctrl_byte[`RX_CTRL_NINE_SEL] = s_q.nine_sel;
		ctrl_byte[`RX_CTRL_RECV_EN] = s_q.recv_en;
		ctrl_byte[`RX_CTRL_ADDR_EN] = s_q.addr_en;
		ctrl_byte[`RX_CTRL_FRAMING_ERROR_BIT] = fifo_head.framing_error_bit;
		ctrl_byte[`RX_CTRL_OVERRUN_ERROR_BIT] = s_q.overrun;
		ctrl_byte[`RX_CTRL_NINTH] = fifo_head.data[8];
		irqen_byte = 8'h00;
		irqen_byte[`RX_IRQEN_GLOBAL] = s_q.global_irq_enable;
		irqen_byte[`RX_IRQEN_PERIPH] = s_q.peripheral_irq_enable;
		irqen_byte[`RX_IRQEN_RX] = s_q.rxie;
		flag_byte = 8'h00;
		flag_byte[`RX_FLAG_CHAR] = s_q.flag;
	end

	// receive sequencer, bus slave and flag logic in one next-state process
	always_comb begin
		s_d = s_q;
		fifo_push = 1'b0;
		fifo_pop = 1'b0;
		push_entry = '0;
		accept = 1'b0;
		rx_run = s_q.port_en && s_q.recv_en;
		line_fall = s_q.line_prev && !line_s;
		decide = sample_tick && (s_q.tick_cnt == `RX_MID_TICK);
		bus_req = wb_cyc_i && wb_stb_i && !s_q.ack;
		s_d.line_prev = line_s;
		if (sample_tick) begin
			s_d.tick_cnt = s_q.tick_cnt + 4'h1;
		end
		unique case (s_q.state)
			rx_pkg::ST_IDLE: begin
				if (rx_run && line_fall) begin
					s_d.state = rx_pkg::ST_START;
					s_d.tick_cnt = 4'h0;
				end
			end
			rx_pkg::ST_START: begin
				if (decide) begin
					if (maj) begin
						s_d.state = rx_pkg::ST_IDLE;
					end else begin
						s_d.state = rx_pkg::ST_DATA;
						s_d.bit_cnt = 4'h0;
					end
				end
			end
			rx_pkg::ST_DATA: begin
				if (decide) begin
					s_d.shift = {maj, s_q.shift[8:1]};
					s_d.bit_cnt = s_q.bit_cnt + 4'h1;
					if (s_q.bit_cnt == (s_q.nine_sel ? `RX_LAST_BIT9 : `RX_LAST_BIT8)) begin
						s_d.state = rx_pkg::ST_STOP;
					end
				end
			end
			rx_pkg::ST_STOP: begin
				if (decide) begin
					// low stop bit marks the entry, reception carries on
					push_entry.framing_error_bit = !maj;
					if (s_q.nine_sel) begin
						push_entry.data = s_q.shift;
					end else begin
						push_entry.data = {1'b0, s_q.shift[8:1]};
					end
					// filter applies only with nine-bit characters selected
					accept = !(s_q.addr_en && s_q.nine_sel && !push_entry.data[8]);
					if (accept && !s_q.overrun) begin
						if (fifo_cnt == 2'(`RX_FIFO_DEPTH)) begin
							s_d.overrun = 1'b1;
						end else begin
							fifo_push = 1'b1;
						end
					end
					s_d.state = rx_pkg::ST_IDLE;
				end
			end
			default: begin
				s_d.state = rx_pkg::ST_IDLE;
			end
		endcase
		// a partial character is dropped when either enable goes away
		if (!rx_run) begin
			s_d.state = rx_pkg::ST_IDLE;
			s_d.overrun = 1'b0;
		end
		// single-wait-state slave: ack one cycle after the strobe
		s_d.ack = bus_req;
		if (bus_req) begin
			s_d.rdata = 32'h0000_0000;
			if (wb_we_i && wb_sel_i[0]) begin
				unique case (wb_adr_i)
					ADDR_W'(`RX_REG_CTRL): begin
						s_d.port_en = wb_dat_i[`RX_CTRL_PORT_EN];
						s_d.nine_sel = wb_dat_i[`RX_CTRL_NINE_SEL];
						s_d.recv_en = wb_dat_i[`RX_CTRL_RECV_EN];
						s_d.addr_en = wb_dat_i[`RX_CTRL_ADDR_EN];
					end
					ADDR_W'(`RX_REG_IRQEN): begin
						s_d.global_irq_enable = wb_dat_i[`RX_IRQEN_GLOBAL];
						s_d.peripheral_irq_enable = wb_dat_i[`RX_IRQEN_PERIPH];
						s_d.rxie = wb_dat_i[`RX_IRQEN_RX];
					end
					default: begin
					end
				endcase
			end else if (!wb_we_i) begin
				unique case (wb_adr_i)
					ADDR_W'(`RX_REG_CTRL): s_d.rdata = {24'h000000, ctrl_byte};
					ADDR_W'(`RX_REG_DATA): begin
						s_d.rdata = {24'h000000, fifo_head.data[7:0]};
						fifo_pop = 1'b1;
					end
					ADDR_W'(`RX_REG_IRQEN): s_d.rdata = {24'h000000, irqen_byte};
					ADDR_W'(`RX_REG_FLAG): s_d.rdata = {24'h000000, flag_byte};
					default: s_d.rdata = 32'h0000_0000;
				endcase
			end
		end
		// flag has no write path; the request alone looks at the interrupt enables
		s_d.flag = rx_run && (fifo_cnt != 2'h0);
		s_d.irq = s_d.flag && s_d.global_irq_enable && s_d.peripheral_irq_enable && s_d.rxie;
	end

	// port disable empties the store, which also clears the framing bit
	assign fifo_flush = !s_q.port_en;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			s_q <= '0;
			s_q.state <= rx_pkg::ST_IDLE;
			s_q.line_prev <= 1'b1;
		end else begin
			s_q <= s_d;
		end
	end

	assign wb_dat_o = s_q.rdata;
	assign wb_ack_o = s_q.ack;
	assign rx_char_flag = s_q.flag;
	assign irq_req = s_q.irq;

	// checks on the receive sequencer and status outputs
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	property p_start_on_fall;
		(s_q.state == rx_pkg::ST_IDLE) ##1 (s_q.state == rx_pkg::ST_START) |->
			$past(line_fall) && $past(rx_run);
	endproperty
	a_start_on_fall: assert property (p_start_on_fall) else $error("start without edge");

	property p_false_start;
		(s_q.state == rx_pkg::ST_START) && decide && maj |=>
			(s_q.state == rx_pkg::ST_IDLE) && $stable(s_q.overrun) && !$past(fifo_push);
	endproperty
	a_false_start: assert property (p_false_start) else $error("false start not dropped");

	property p_stop_push;
		(s_q.state == rx_pkg::ST_STOP) && decide && accept && !s_q.overrun &&
			(fifo_cnt != 2'h2) |-> fifo_push && (push_entry.framing_error_bit == !maj);
	endproperty
	a_stop_push: assert property (p_stop_push) else $error("stop did not store character");

	property p_flag_follows;
		##1 1'b1 |-> rx_char_flag == ($past(rx_run) && ($past(fifo_cnt) != 2'h0));
	endproperty
	a_flag_follows: assert property (p_flag_follows) else $error("flag mismatch");

	property p_irq_gate;
		irq_req |-> rx_char_flag && s_q.global_irq_enable && s_q.peripheral_irq_enable && s_q.rxie;
	endproperty
	a_irq_gate: assert property (p_irq_gate) else $error("request without enables");

	property p_port_off_clears;
		!s_q.port_en |=> (fifo_cnt == 2'h0) && !fifo_head.framing_error_bit && !s_q.overrun;
	endproperty
	a_port_off_clears: assert property (p_port_off_clears) else $error("port off kept state");

	property p_overrun_set;
		(s_q.state == rx_pkg::ST_STOP) && decide && accept && (fifo_cnt == 2'h2) &&
			rx_run |=> s_q.overrun;
	endproperty
	a_overrun_set: assert property (p_overrun_set) else $error("overrun missed");

	property p_overrun_blocks;
		s_q.overrun |-> !fifo_push;
	endproperty
	a_overrun_blocks: assert property (p_overrun_blocks) else $error("push during overrun");

	property p_overrun_clear;
		!s_q.recv_en |=> !s_q.overrun;
	endproperty
	a_overrun_clear: assert property (p_overrun_clear) else $error("overrun kept");

	property p_filter;
		fifo_push && s_q.addr_en && s_q.nine_sel |-> push_entry.data[8];
	endproperty
	a_filter: assert property (p_filter) else $error("filtered character stored");

	property p_abandon;
		!rx_run |=> s_q.state == rx_pkg::ST_IDLE;
	endproperty
	a_abandon: assert property (p_abandon) else $error("partial kept");

	property p_ack_one;
		wb_ack_o |=> !wb_ack_o;
	endproperty
	a_ack_one: assert property (p_ack_one) else $error("ack held");

	// a confirmed low start centre moves on to the data bits
	property p_start_confirm;
		(s_q.state == rx_pkg::ST_START) && decide && !maj && rx_run |=>
			(s_q.state == rx_pkg::ST_DATA) && (s_q.bit_cnt == 4'h0);
	endproperty
	a_start_confirm: assert property (p_start_confirm) else $error("start not confirmed");

	// the last data decision hands over to the stop bit
	property p_data_to_stop;
		(s_q.state == rx_pkg::ST_DATA) && decide && rx_run &&
			(s_q.bit_cnt == (s_q.nine_sel ? `RX_LAST_BIT9 : `RX_LAST_BIT8)) |=>
			(s_q.state == rx_pkg::ST_STOP);
	endproperty
	a_data_to_stop: assert property (p_data_to_stop) else $error("bit count overrun");

	// back to edge search right after the stop decision, mid stop bit
	property p_stop_idle;
		(s_q.state == rx_pkg::ST_STOP) && decide |=> (s_q.state == rx_pkg::ST_IDLE);
	endproperty
	a_stop_idle: assert property (p_stop_idle) else $error("stop did not end frame");

	// a data read with nothing arriving removes exactly one entry
	property p_pop_advances;
		fifo_pop && (fifo_cnt != 2'h0) && !fifo_push && s_q.port_en |=>
			(fifo_cnt == $past(fifo_cnt) - 2'h1);
	endproperty
	a_pop_advances: assert property (p_pop_advances) else $error("read did not advance");

	// never push into a full store
	property p_push_not_full;
		fifo_push |-> (fifo_cnt != 2'h2);
	endproperty
	a_push_not_full: assert property (p_push_not_full) else $error("push while full");

	// flag plus all three enables gives a request
	property p_irq_set;
		rx_char_flag && s_q.global_irq_enable && s_q.peripheral_irq_enable && s_q.rxie |-> irq_req;
	endproperty
	a_irq_set: assert property (p_irq_set) else $error("request missing");

	// registers sit in the low byte lane only
	property p_ack_upper;
		wb_ack_o |-> (wb_dat_o[31:8] == 24'h000000);
	endproperty
	a_ack_upper: assert property (p_ack_upper) else $error("upper read lanes set");

	c_char_stored: cover property (fifo_push && !push_entry.framing_error_bit);
	c_ninth: cover property (fifo_push && push_entry.data[8]);
	c_framing: cover property (fifo_push && push_entry.framing_error_bit);
	c_overrun: cover property (!s_q.overrun ##1 s_q.overrun);
	c_false_start: cover property ((s_q.state == rx_pkg::ST_START) && decide && maj);
endmodule

// file: design/rx_cfg.svh
`ifndef RX_CFG_SVH
`define RX_CFG_SVH

// register byte offsets
`define RX_REG_CTRL 8'h00
`define RX_REG_DATA 8'h04
`define RX_REG_IRQEN 8'h08
`define RX_REG_FLAG 8'h0C

// control/status byte fields
`define RX_CTRL_PORT_EN 7
`define RX_CTRL_NINE_SEL 6
`define RX_CTRL_RECV_EN 4
`define RX_CTRL_ADDR_EN 3
`define RX_CTRL_FRAMING_ERROR_BIT 2
`define RX_CTRL_OVERRUN_ERROR_BIT 1
`define RX_CTRL_NINTH 0

// interrupt enable byte fields
`define RX_IRQEN_GLOBAL 7
`define RX_IRQEN_PERIPH 6
`define RX_IRQEN_RX 5

// flag byte field
`define RX_FLAG_CHAR 5

// reset values of the writable bytes
`define RX_CTRL_RESET 8'h00
`define RX_IRQEN_RESET 8'h00

// oversampling timing in sample ticks, and last data bit numbers
`define RX_OVERSAMPLE 16
`define RX_MID_TICK 4'h7
`define RX_LAST_BIT8 4'h7
`define RX_LAST_BIT9 4'h8

// receive fifo
`define RX_FIFO_DEPTH 2

`endif

// file: design/rx_fifo.sv
`timescale 1ns/100ps
`include "rx_cfg.svh"
// two-entry character store; oldest entry is held in a register
module rx_fifo (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic flush,
	input wire logic push,
	input wire rx_pkg::rx_entry_type push_entry,
	input wire logic pop,
	output rx_pkg::rx_entry_type head,
	output logic [1:0] count
);
	rx_pkg::rx_fifo_state_type s_q, s_d;
	logic do_pop;
	logic do_push;

	// flush beats everything, so a port reset leaves no stale framing status
	always_comb begin
		s_d = s_q;
		do_pop = pop && (s_q.cnt != 2'h0);
		do_push = push && (s_q.cnt != 2'(`RX_FIFO_DEPTH));
		if (do_push) begin
			s_d.mem[s_q.wr_ptr] = push_entry;
			s_d.wr_ptr = ~s_q.wr_ptr;
		end
		if (do_pop) begin
			s_d.rd_ptr = ~s_q.rd_ptr;
		end
		s_d.cnt = s_q.cnt + 2'(do_push) - 2'(do_pop);
		if (flush) begin
			s_d = '0;
		end
		s_d.head = (s_d.cnt != 2'h0) ? s_d.mem[s_d.rd_ptr] : '0;
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign head = s_q.head;
	assign count = s_q.cnt;
endmodule

// file: design/rx_pkg.sv
package rx_pkg;

	typedef enum logic [3:0] {
		ST_IDLE = 4'h1,
		ST_START = 4'h2,
		ST_DATA = 4'h4,
		ST_STOP = 4'h8
	} rx_state_type;

	typedef struct packed {
		logic framing_error_bit;
		logic [8:0] data;
	} rx_entry_type;

	typedef struct packed {
		rx_entry_type [1:0] mem;
		logic wr_ptr;
		logic rd_ptr;
		logic [1:0] cnt;
		rx_entry_type head;
	} rx_fifo_state_type;

	typedef struct packed {
		logic sync1;
		logic sync2;
		logic [1:0] hist;
	} rx_sampler_state_type;

	typedef struct packed {
		rx_state_type state;
		logic [3:0] tick_cnt;
		logic [3:0] bit_cnt;
		logic [8:0] shift;
		logic line_prev;
		logic port_en;
		logic nine_sel;
		logic recv_en;
		logic addr_en;
		logic global_irq_enable;
		logic peripheral_irq_enable;
		logic rxie;
		logic overrun;
		logic ack;
		logic [31:0] rdata;
		logic flag;
		logic irq;
	} rx_top_state_type;

endpackage

// file: design/rx_sampler.sv
`timescale 1ns/100ps
// two-flop synchroniser plus three-sample majority vote on the oversampling tick
module rx_sampler (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic serial_input_pin,
	input wire logic sample_tick,
	output logic line_s,
	output logic maj
);
	rx_pkg::rx_sampler_state_type s_q, s_d;

	// sync1 feeds sync2 only; history is built from the second stage
	always_comb begin
		s_d = s_q;
		s_d.sync1 = serial_input_pin;
		s_d.sync2 = s_q.sync1;
		if (sample_tick) begin
			s_d.hist = {s_q.hist[0], s_q.sync2};
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			s_q <= '{sync1: 1'b1, sync2: 1'b1, hist: 2'h3};
		end else begin
			s_q <= s_d;
		end
	end

	assign line_s = s_q.sync2;
	// two earlier ticks plus the present level, at least two of three win
	assign maj = (s_q.hist[1] & s_q.hist[0]) | (s_q.hist[1] & s_q.sync2) |
		(s_q.hist[0] & s_q.sync2);
endmodule

// file: sim/serial_tx_model.sv
`timescale 1ns/100ps
// far-side transmitter: one bit lasts sixteen sample ticks, line idles high
module serial_tx_model (
	input wire logic clk,
	input wire logic sample_tick,
	output logic line
);
	initial line = 1'b1;

	// waits are counted in ticks so bit length follows the tick rate
	task automatic ticks(input int n);
		repeat (n) @(posedge clk iff sample_tick);
	endtask

	task automatic put(input logic v);
		line <= v;
		ticks(16);
	endtask

	// one frame, least significant bit first
	task automatic send(input logic [8:0] d, input int n, input logic stp);
		put(1'b0);
		for (int i = 0; i < n; i++) begin
			put(d[i]);
		end
		put(stp);
		line <= 1'b1;
		ticks(4);
	endtask

	// low pulse too short to reach the start centre
	task automatic glitch();
		line <= 1'b0;
		ticks(4);
		line <= 1'b1;
		ticks(32);
	endtask
endmodule

// file: sim/testbench.sv
`timescale 1ns/100ps
`define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin error_cnt++; \
	$display("Error %s exp %h got %h", n, e, g); end end
module testbench;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic cyc = 1'b0;
	logic stb = 1'b0;
	logic we = 1'b0;
	logic [7:0] adr = 8'h00;
	logic [31:0] wdat = 32'h0;
	logic [31:0] rdat;
	logic ack;
	logic line;
	logic tick = 1'b0;
	logic [1:0] div = 2'h0;
	logic flag;
	logic irq;
	int error_cnt = 0;
	int cmp_count = 0;

	always #2.5 clk = ~clk;

	// one tick every four clocks keeps frames short
	always @(posedge clk) begin
		div <= div + 2'h1;
		tick <= (div == 2'h3);
	end

	async_serial_receiver async_serial_receiver_inst (.clk(clk), .rst_n(rst_n),
		.wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF),
		.wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .serial_input_pin(line),
		.sample_tick(tick), .rx_char_flag(flag), .irq_req(irq));

	serial_tx_model serial_tx_model_inst (.clk(clk), .sample_tick(tick), .line(line));

	task automatic summarize();
		if (error_cnt == 0 && cmp_count > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask

	// classic cycle: hold request until ack is seen, then idle one cycle
	task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] v,
		output logic [31:0] q);
		int n;
		n = 0;
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= {24'h0, v};
		do begin
			@(posedge clk);
			n++;
		end while (ack !== 1'b1 && n < 50);
		if (n >= 50) begin
			error_cnt++;
			$display("Error bus ack exp 1 got %b", ack);
		end
		q = rdat;
		cyc <= 1'b0;
		stb <= 1'b0;
		@(posedge clk);
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] v);
		logic [31:0] q;
		bus(1'b1, a, v, q);
	endtask

	task automatic rc(input string n, input logic [7:0] a, input logic [7:0] e);
		logic [31:0] q;
		bus(1'b0, a, 8'h00, q);
		`CHK(n, {24'h0, e}, q)
	endtask

	task automatic tx(input logic [8:0] d, input int n, input logic stp);
		serial_tx_model_inst.send(d, n, stp);
	endtask

	// watchdog sized well beyond the 12 frames sent
	initial begin
		#200000;
		error_cnt++;
		summarize();
	end

	initial begin
		repeat (3) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		rc("ctrl", 8'h00, 8'h00);
		rc("irqen", 8'h08, 8'h00);
		rc("unmapped", 8'h10, 8'h00);
		// port first, then receiver
		wr(8'h00, 8'h80);
		wr(8'h00, 8'h90);
		tx(9'h0A5, 8, 1'b1);
		`CHK("flag", 1'b1, flag)
		`CHK("irq", 1'b0, irq)
		rc("flagreg", 8'h0C, 8'h20);
		rc("data", 8'h04, 8'hA5);
		rc("flagreg", 8'h0C, 8'h00);
		// bad stop then good character
		tx(9'h03C, 8, 1'b0);
		tx(9'h05A, 8, 1'b1);
		rc("ctrl", 8'h00, 8'h94);
		rc("data", 8'h04, 8'h3C);
		rc("ctrl", 8'h00, 8'h90);
		rc("data", 8'h04, 8'h5A);
		// false start is dropped silently
		serial_tx_model_inst.glitch();
		tx(9'h011, 8, 1'b1);
		rc("ctrl", 8'h00, 8'h90);
		rc("data", 8'h04, 8'h11);
		rc("data", 8'h04, 8'h00);
		// third whole character overruns, fourth refused
		tx(9'h001, 8, 1'b1);
		tx(9'h002, 8, 1'b1);
		tx(9'h003, 8, 1'b1);
		rc("ctrl", 8'h00, 8'h92);
		tx(9'h004, 8, 1'b1);
		rc("data", 8'h04, 8'h01);
		rc("data", 8'h04, 8'h02);
		rc("data", 8'h04, 8'h00);
		wr(8'h00, 8'h80);
		rc("ctrl", 8'h00, 8'h80);
		wr(8'h00, 8'h90);
		// receive disable keeps framing bit, port disable clears it
		tx(9'h077, 8, 1'b0);
		wr(8'h00, 8'h80);
		rc("ctrl", 8'h00, 8'h84);
		`CHK("flag", 1'b0, flag)
		wr(8'h00, 8'h00);
		rc("ctrl", 8'h00, 8'h00);
		// nine-bit with all interrupt enables
		wr(8'h08, 8'hE0);
		wr(8'h00, 8'h80);
		wr(8'h00, 8'hD0);
		tx(9'h1AB, 9, 1'b1);
		`CHK("irq", 1'b1, irq)
		wr(8'h08, 8'hC0);
		`CHK("irq", 1'b0, irq)
		`CHK("flag", 1'b1, flag)
		rc("ctrl", 8'h00, 8'hD1);
		rc("data", 8'h04, 8'hAB);
		// filter keeps only ninth-bit-set characters
		wr(8'h00, 8'hD8);
		tx(9'h055, 9, 1'b1);
		tx(9'h1C3, 9, 1'b1);
		rc("ctrl", 8'h00, 8'hD9);
		rc("data", 8'h04, 8'hC3);
		rc("flagreg", 8'h0C, 8'h00);
		wr(8'h00, 8'hD0);
		summarize();
	end
endmodule
